// [design/fan_lut_pkg.sv]
// Constants shared by the fan look-up table block
package fan_lut_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] PUSHED1_ADDR = 8'h0C;
   localparam logic [7:0] PUSHED2_ADDR = 8'h0D;
   localparam logic [7:0] FAN_CTRL_ADDR = 8'h42;
   localparam logic [7:0] FAN_SPIN_ADDR = 8'h46;
   localparam logic [7:0] LUT_CFG_ADDR = 8'h50;
   localparam logic [7:0] LUT_FIRST_ADDR = 8'h51;
   localparam logic [7:0] LUT_LAST_ADDR = 8'h78;
   localparam logic [7:0] HYST_ADDR = 8'h79;
   localparam logic [7:0] RESULT_ADDR = 8'h7A;
   // ----------------------------------------
   // Table geometry
   // ----------------------------------------
   localparam int STEPS = 8;
   localparam int CHANNELS = 4;
   localparam int CELLS_PER_STEP = 5;
   localparam int LUT_DEPTH = 40;
   localparam int LUT_AW = 6;
   localparam logic [7:0] CELL_RESET = 8'hFF;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CFG_TRANSLATE1_BIT = 7;
   localparam int CFG_TRANSLATE2_BIT = 6;
   localparam int CFG_LOCK_BIT = 5;
   localparam int CFG_DRIVE_SEL_BIT = 4;
   localparam int CFG_THIRD_SRC_BIT = 2;
   localparam int CFG_FOURTH_SRC_BIT = 0;
   localparam int FAN_LOOP_EN_BIT = 7;
   localparam int FAN_EDGES_LSB = 3;
   localparam int SPIN_LEVEL_LSB = 2;
   localparam int SPIN_DUR_LSB = 0;
   // ----------------------------------------
   // Reset values and fixed figures
   // ----------------------------------------
   localparam logic [7:0] FAN_CTRL_RESET = 8'h00;
   localparam logic [7:0] FAN_SPIN_RESET = 8'h00;
   localparam logic [7:0] LUT_CFG_RESET = 8'h00;
   localparam logic [7:0] HYST_RESET = 8'h00;
   localparam logic [7:0] TRANSLATE_REF_TEMP = 8'h64;
   localparam logic [7:0] DRIVE_IDLE = 8'h00;
   localparam logic [7:0] TACH_IDLE = 8'hFF;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SPIN_UNIT_MS = 250;
   localparam int SPIN_UNIT_CYCLES = SPIN_UNIT_MS * 1000000 / CLK_PERIOD_NS;
   // ----------------------------------------
   // Evaluation sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      IDLE = 3'b000,
      THRESH = 3'b001,
      DRAIN_T = 3'b010,
      RESOLVE = 3'b011,
      DRIVE_RD = 3'b100,
      DRAIN_D = 3'b101,
      APPLY = 3'b110
   } eval_e;
endpackage

// [design/lut_memory.sv]
// Table cell storage with one write port and two registered read ports
`timescale 1ns/1ps
module lut_memory #(
   parameter int W = 8,
   parameter int DEPTH = 40,
   parameter int AW = 6
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [W-1:0] wrData,
   input wire logic [AW-1:0] rdAddrA,
   output logic [W-1:0] rdDataA,
   input wire logic [AW-1:0] rdAddrB,
   output logic [W-1:0] rdDataB
);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] cells;
      logic [W-1:0] rdA;
      logic [W-1:0] rdB;
   } mem_s;

   mem_s st;
   mem_s next_st;

   if (DEPTH > (1 << AW) || W < 1) begin : g_check
      $error("lut_memory: depth does not fit the address width");
   end

   always_comb begin
      next_st = st;
      next_st.rdA = (int'(rdAddrA) < DEPTH) ? st.cells[rdAddrA] : '0;
      next_st.rdB = (int'(rdAddrB) < DEPTH) ? st.cells[rdAddrB] : '0;
      if (wrEn && int'(wrAddr) < DEPTH) begin
         next_st.cells[wrAddr] = wrData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st.cells <= {DEPTH{fan_lut_pkg::CELL_RESET}};
         st.rdA <= '0;
         st.rdB <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdDataA = st.rdA;
   assign rdDataB = st.rdB;
endmodule

// [design/fan_lut_ctrl.sv]
// Temperature look-up table that selects the fan drive or tach target
// What this block does
// - Translated pushed value equals 100 minus stored value, or zero when stored value is above 100
// - Every table cell host readable; writable only while the lock bit is clear
// - Drive select picks duty or tach target
// - Channels independent; most demanding setting wins
// - Spin-up holds spin level for programmed duration
// - Table holds eight steps, four thresholds each
// - Step taken when temperature meets its threshold
// - Fall back below threshold minus hysteresis
`timescale 1ns/1ps
module fan_lut_ctrl #(
   parameter int unsigned SPIN_UNIT_CYCLES = fan_lut_pkg::SPIN_UNIT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic [3:0][7:0] tempIn,
   input wire logic tempValid,
   output logic [7:0] pwmDuty,
   output logic [7:0] tachTarget,
   output logic spinActive,
   output logic [2:0] spinLevel
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      fan_lut_pkg::eval_e state;
      logic [5:0] idx;
      logic [5:0] capIdx;
      logic pending;
      logic [7:0] fanCfg;
      logic [7:0] spinCfg;
      logic [7:0] lutCfg;
      logic [7:0] pushed1;
      logic [7:0] pushed2;
      logic [7:0] hyst;
      logic [3:0][7:0] snap;
      logic [3:0][3:0] cand;
      logic [3:0][3:0] cur;
      logic [3:0][7:0] thrCur;
      logic [7:0] best;
      logic bestOn;
      logic [7:0] pwmDuty;
      logic [7:0] tachTarget;
      logic [7:0] result;
      logic rdPend;
      logic [7:0] rdAddr;
      logic [7:0] rdData;
      logic rdValid;
      logic loopWas;
      logic spinActive;
      logic [31:0] spinCnt;
   } ctrl_s;

   ctrl_s st;
   ctrl_s next_st;

   logic [7:0] lutOff;
   logic inLut;
   logic locked;
   logic driveMode;
   logic memWr;
   logic [5:0] scanAddr;
   logic [3:0] drvStep;
   logic [5:0] drvAddr;
   logic [7:0] rdDataA;
   logic [7:0] rdDataB;
   logic [3:0][7:0] effTemp;
   logic [7:0] pushEff1;
   logic [7:0] pushEff2;
   logic startScan;
   logic loopOn;

   if (SPIN_UNIT_CYCLES < 2 || SPIN_UNIT_CYCLES > 32'h1000_0000) begin : g_check
      $error("fan_lut_ctrl: spin unit out of range");
   end

   // ----------------------------------------
   // Register decode and table storage
   // ----------------------------------------
   assign lutOff = regAddr - fan_lut_pkg::LUT_FIRST_ADDR;
   assign inLut = regAddr >= fan_lut_pkg::LUT_FIRST_ADDR && regAddr <= fan_lut_pkg::LUT_LAST_ADDR;
   assign locked = st.lutCfg[fan_lut_pkg::CFG_LOCK_BIT];
   assign driveMode = st.lutCfg[fan_lut_pkg::CFG_DRIVE_SEL_BIT];
   assign memWr = regWr && inLut && !locked;
   assign scanAddr = ({3'b000, st.idx[4:2]} * 6'd5) + 6'd1 + {4'b0000, st.idx[1:0]};
   assign drvStep = st.cur[st.idx[1:0]] - 4'd1;
   assign drvAddr = {2'b00, drvStep} * 6'd5;

   lut_memory #(
      .W(8),
      .DEPTH(fan_lut_pkg::LUT_DEPTH),
      .AW(fan_lut_pkg::LUT_AW)
   ) u_mem (
      .ref_clk(ref_clk),
      .rst(rst),
      .wrEn(memWr),
      .wrAddr(lutOff[5:0]),
      .wrData(regWrData),
      .rdAddrA(lutOff[5:0]),
      .rdDataA(rdDataA),
      .rdAddrB(st.state == fan_lut_pkg::THRESH ? scanAddr : drvAddr),
      .rdDataB(rdDataB)
   );

   // ----------------------------------------
   // Input channel sources
   // ----------------------------------------
   always_comb begin
      pushEff1 = st.pushed1;
      pushEff2 = st.pushed2;
      if (st.lutCfg[fan_lut_pkg::CFG_TRANSLATE1_BIT]) begin
         pushEff1 = (st.pushed1 > fan_lut_pkg::TRANSLATE_REF_TEMP) ? 8'h00 :
            fan_lut_pkg::TRANSLATE_REF_TEMP - st.pushed1;
      end
      if (st.lutCfg[fan_lut_pkg::CFG_TRANSLATE2_BIT]) begin
         pushEff2 = (st.pushed2 > fan_lut_pkg::TRANSLATE_REF_TEMP) ? 8'h00 :
            fan_lut_pkg::TRANSLATE_REF_TEMP - st.pushed2;
      end
      effTemp[0] = tempIn[0];
      effTemp[1] = tempIn[1];
      effTemp[2] = st.lutCfg[fan_lut_pkg::CFG_THIRD_SRC_BIT] ? pushEff1 : tempIn[2];
      effTemp[3] = st.lutCfg[fan_lut_pkg::CFG_FOURTH_SRC_BIT] ? pushEff2 : tempIn[3];
   end

   assign startScan = st.state == fan_lut_pkg::IDLE && st.pending;
   assign loopOn = st.fanCfg[fan_lut_pkg::FAN_LOOP_EN_BIT] && !driveMode;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      // Register writes
      if (regWr && !locked) begin
         case (regAddr)
            fan_lut_pkg::LUT_CFG_ADDR: next_st.lutCfg = regWrData;
            fan_lut_pkg::HYST_ADDR: next_st.hyst = regWrData;
            default: ;
         endcase
      end
      if (regWr) begin
         case (regAddr)
            fan_lut_pkg::FAN_CTRL_ADDR: next_st.fanCfg = regWrData;
            fan_lut_pkg::FAN_SPIN_ADDR: next_st.spinCfg = regWrData;
            fan_lut_pkg::PUSHED1_ADDR: next_st.pushed1 = regWrData;
            fan_lut_pkg::PUSHED2_ADDR: next_st.pushed2 = regWrData;
            default: ;
         endcase
      end
      // Any new input or table change asks for a fresh pass; a new request wins over the clear
      next_st.pending = (st.pending && !startScan) || tempValid ||
         (regWr && (regAddr == fan_lut_pkg::PUSHED1_ADDR || regAddr == fan_lut_pkg::PUSHED2_ADDR ||
         regAddr == fan_lut_pkg::LUT_CFG_ADDR || regAddr == fan_lut_pkg::HYST_ADDR || inLut));
      // Register reads: address taken, then data on the next edge
      next_st.rdPend = regRd;
      next_st.rdAddr = regAddr;
      next_st.rdValid = st.rdPend;
      if (st.rdPend) begin
         if (st.rdAddr >= fan_lut_pkg::LUT_FIRST_ADDR && st.rdAddr <= fan_lut_pkg::LUT_LAST_ADDR) begin
            next_st.rdData = rdDataA;
         end else begin
            case (st.rdAddr)
               fan_lut_pkg::FAN_CTRL_ADDR: next_st.rdData = st.fanCfg;
               fan_lut_pkg::FAN_SPIN_ADDR: next_st.rdData = st.spinCfg;
               fan_lut_pkg::LUT_CFG_ADDR: next_st.rdData = st.lutCfg;
               fan_lut_pkg::PUSHED1_ADDR: next_st.rdData = st.pushed1;
               fan_lut_pkg::PUSHED2_ADDR: next_st.rdData = st.pushed2;
               fan_lut_pkg::HYST_ADDR: next_st.rdData = st.hyst;
               fan_lut_pkg::RESULT_ADDR: next_st.rdData = st.result;
               default: next_st.rdData = 8'h00;
            endcase
         end
      end
      // Evaluation sequencer
      case (st.state)
         fan_lut_pkg::IDLE: begin
            if (st.pending) begin
               next_st.state = fan_lut_pkg::THRESH;
               next_st.idx = 6'd0;
               next_st.snap = effTemp;
               next_st.cand = '0;
               next_st.bestOn = 1'b0;
            end
         end
         fan_lut_pkg::THRESH, fan_lut_pkg::DRAIN_T: begin
            if (st.state == fan_lut_pkg::THRESH && st.idx != 6'd0 || st.state == fan_lut_pkg::DRAIN_T) begin
               // Ascending scan leaves the highest met step
               if (st.snap[st.capIdx[1:0]] >= rdDataB) begin
                  next_st.cand[st.capIdx[1:0]] = {1'b0, st.capIdx[4:2]} + 4'd1;
               end
               if ({1'b0, st.capIdx[4:2]} + 4'd1 == st.cur[st.capIdx[1:0]]) begin
                  next_st.thrCur[st.capIdx[1:0]] = rdDataB;
               end
            end
            next_st.capIdx = st.idx;
            next_st.idx = st.idx + 6'd1;
            if (st.state == fan_lut_pkg::DRAIN_T) begin
               next_st.state = fan_lut_pkg::RESOLVE;
            end else if (st.idx == 6'd31) begin
               next_st.state = fan_lut_pkg::DRAIN_T;
            end
         end
         fan_lut_pkg::RESOLVE: begin
            for (int c = 0; c < fan_lut_pkg::CHANNELS; c++) begin
               if (st.cand[c] >= st.cur[c]) begin
                  next_st.cur[c] = st.cand[c];
               end else if ({1'b0, st.snap[c]} + {1'b0, st.hyst} < {1'b0, st.thrCur[c]}) begin
                  next_st.cur[c] = st.cand[c];
               end
            end
            next_st.idx = 6'd0;
            next_st.state = fan_lut_pkg::DRIVE_RD;
         end
         fan_lut_pkg::DRIVE_RD, fan_lut_pkg::DRAIN_D: begin
            if (st.state == fan_lut_pkg::DRIVE_RD && st.idx != 6'd0 || st.state == fan_lut_pkg::DRAIN_D) begin
               if (st.cur[st.capIdx[1:0]] != 4'd0) begin
                  // Drive mode wants the larger duty, speed mode the smaller tach count
                  if (!st.bestOn || (driveMode ? rdDataB > st.best : rdDataB < st.best)) begin
                     next_st.best = rdDataB;
                  end
                  next_st.bestOn = 1'b1;
               end
            end
            next_st.capIdx = st.idx;
            next_st.idx = st.idx + 6'd1;
            if (st.state == fan_lut_pkg::DRAIN_D) begin
               next_st.state = fan_lut_pkg::APPLY;
            end else if (st.idx == 6'd3) begin
               next_st.state = fan_lut_pkg::DRAIN_D;
            end
         end
         fan_lut_pkg::APPLY: begin
            if (driveMode) begin
               next_st.pwmDuty = st.bestOn ? st.best : fan_lut_pkg::DRIVE_IDLE;
               next_st.result = st.bestOn ? st.best : fan_lut_pkg::DRIVE_IDLE;
            end else begin
               next_st.tachTarget = st.bestOn ? st.best : fan_lut_pkg::TACH_IDLE;
               next_st.result = st.bestOn ? st.best : fan_lut_pkg::TACH_IDLE;
            end
            next_st.state = fan_lut_pkg::IDLE;
         end
         default: next_st.state = fan_lut_pkg::IDLE;
      endcase
      // Spin-up when the speed loop is switched on
      next_st.loopWas = loopOn;
      if (!loopOn) begin
         next_st.spinActive = 1'b0;
      end else if (!st.loopWas) begin
         next_st.spinActive = 1'b1;
         next_st.spinCnt = (SPIN_UNIT_CYCLES << st.spinCfg[fan_lut_pkg::SPIN_DUR_LSB +: 2]) - 32'd1;
      end else if (st.spinActive) begin
         if (st.spinCnt == 32'd0) begin
            next_st.spinActive = 1'b0;
         end else begin
            next_st.spinCnt = st.spinCnt - 32'd1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
         st.state <= fan_lut_pkg::IDLE;
         st.fanCfg <= fan_lut_pkg::FAN_CTRL_RESET;
         st.spinCfg <= fan_lut_pkg::FAN_SPIN_RESET;
         st.lutCfg <= fan_lut_pkg::LUT_CFG_RESET;
         st.hyst <= fan_lut_pkg::HYST_RESET;
         st.tachTarget <= fan_lut_pkg::TACH_IDLE;
         st.pwmDuty <= fan_lut_pkg::DRIVE_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign regRdData = st.rdData;
   assign regRdValid = st.rdValid;
   assign pwmDuty = st.pwmDuty;
   assign tachTarget = st.tachTarget;
   assign spinActive = st.spinActive;
   assign spinLevel = st.spinCfg[fan_lut_pkg::SPIN_LEVEL_LSB +: 3];

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence scanStart;
      st.state == fan_lut_pkg::IDLE && st.pending;
   endsequence
   sequence scanEnd;
      st.state == fan_lut_pkg::APPLY;
   endsequence

   a_read_latency: assert property (regRd |-> ##2 regRdValid)
      else $error("read data not returned two cycles after request");
   a_cfg_locked: assert property (regWr && regAddr == fan_lut_pkg::LUT_CFG_ADDR && locked |=> $stable(st.lutCfg))
      else $error("locked configuration changed");
   a_scan_span: assert property (scanStart |-> ##40 scanEnd)
      else $error("evaluation pass not forty cycles long");
   a_new_reading: assert property (tempValid |-> ##[1:81] scanEnd)
      else $error("new reading not applied in time");
   a_drive_apply: assert property (scanEnd and (driveMode && st.bestOn) |=> pwmDuty == $past(st.best))
      else $error("drive setting not applied to duty");
   a_tach_apply: assert property (scanEnd and (!driveMode && st.bestOn) |=>
      tachTarget == $past(st.best) && $stable(pwmDuty))
      else $error("tach target not applied");
   a_translate_in: assert property (startScan && st.lutCfg[fan_lut_pkg::CFG_TRANSLATE1_BIT] &&
      st.lutCfg[fan_lut_pkg::CFG_THIRD_SRC_BIT] && st.pushed1 <= fan_lut_pkg::TRANSLATE_REF_TEMP |=>
      st.snap[2] == fan_lut_pkg::TRANSLATE_REF_TEMP - $past(st.pushed1))
      else $error("pushed value not translated");
   a_step_rise: assert property (st.state == fan_lut_pkg::RESOLVE && st.cand[0] >= st.cur[0] |=>
      st.cur[0] == $past(st.cand[0]))
      else $error("met step not taken");
   a_hyst_hold: assert property (st.state == fan_lut_pkg::RESOLVE && st.cand[0] < st.cur[0] &&
      {1'b0, st.snap[0]} + {1'b0, st.hyst} >= {1'b0, st.thrCur[0]} |=> $stable(st.cur[0]))
      else $error("step fell back inside hysteresis");
   a_best_grow: assert property ((st.state == fan_lut_pkg::DRAIN_D || st.state == fan_lut_pkg::DRIVE_RD) &&
      driveMode && st.bestOn |=> st.best >= $past(st.best))
      else $error("selected duty decreased during merge");
   a_spin_hold: assert property ($rose(st.spinActive) |-> st.spinActive [*2])
      else $error("spin-up ended too early");
endmodule

// [bench/lut_host_model.sv]
// Host model that programs the fan table through the register port
`timescale 1ns/1ps
module lut_host_model (
   input wire logic ref_clk,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   output logic regWr,
   output logic regRd,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid
);
   initial begin
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end

   // ----------------------------------------
   // Register accesses
   // ----------------------------------------
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      #1;
      regAddr = addr;
      regWrData = data;
      regWr = 1'b1;
      @(posedge ref_clk);
      #1;
      regWr = 1'b0;
      // Released lines never keep the last value
      regAddr = ~addr;
      regWrData = ~data;
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic answered);
      answered = 1'b0;
      data = 8'h00;
      @(posedge ref_clk);
      #1;
      regAddr = addr;
      regRd = 1'b1;
      @(posedge ref_clk);
      #1;
      regRd = 1'b0;
      regAddr = ~addr;
      for (int i = 0; i < 4 && !answered; i++) begin
         @(posedge ref_clk);
         #1;
         if (regRdValid === 1'b1) begin
            answered = 1'b1;
            data = regRdData;
         end
      end
   endtask
endmodule

// [bench/fan_lut_ctrl_bench.sv]
// Self-checking bench for the fan look-up table block
`timescale 1ns/1ps
module fan_lut_ctrl_bench;
   localparam int SPIN_UNIT = 4;
   localparam int EVAL_WAIT = 85;
   logic ref_clk;
   logic rst;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic regWr;
   logic regRd;
   logic [7:0] regRdData;
   logic regRdValid;
   logic [3:0][7:0] tempIn;
   logic tempValid;
   logic [7:0] pwmDuty;
   logic [7:0] tachTarget;
   logic spinActive;
   logic [2:0] spinLevel;
   int miscompares;
   int tests_run;
   int spinCount;
   logic [7:0] thr1 [8] = '{8'h23, 8'h28, 8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A, 8'h64};
   logic [7:0] thr2 [8] = '{8'h3C, 8'h46, 8'h4B, 8'h50, 8'h55, 8'h5A, 8'h5F, 8'h64};
   logic [7:0] duty [8] = '{8'h00, 8'h4D, 8'h66, 8'h80, 8'h99, 8'hB3, 8'hCC, 8'hFF};
   logic [7:0] tach [8] = '{8'hF4, 8'hC4, 8'hA0, 8'h78, 8'h60, 8'h52, 8'h46, 8'h3D};

   fan_lut_ctrl #(.SPIN_UNIT_CYCLES(SPIN_UNIT)) u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid),
      .tempIn(tempIn), .tempValid(tempValid), .pwmDuty(pwmDuty), .tachTarget(tachTarget),
      .spinActive(spinActive), .spinLevel(spinLevel));

   lut_host_model u_host (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid));

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] thrOf(input int c, input int s);
      case (c)
         0: thrOf = thr1[s];
         1: thrOf = thr2[s];
         2: thrOf = 8'(30 + 5 * s);
         default: thrOf = 8'(40 + 5 * s);
      endcase
   endfunction

   function automatic logic [7:0] cellAddr(input int s, input int k);
      cellAddr = 8'(fan_lut_pkg::LUT_FIRST_ADDR + 5 * s + k);
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] expected);
      tests_run++;
      if (seen !== expected) begin
         miscompares++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expected);
      end
   endtask

   task automatic read_check(input logic [7:0] addr, input logic [7:0] expected);
      logic [7:0] data;
      logic answered;
      u_host.read_reg(addr, data, answered);
      check({7'h00, answered}, 8'h01);
      check(data, expected);
   endtask

   task automatic settle;
      repeat (EVAL_WAIT) @(posedge ref_clk);
      #1;
   endtask

   task automatic set_temps(input logic [7:0] t0, input logic [7:0] t1, input logic [7:0] t2,
                            input logic [7:0] t3);
      @(posedge ref_clk);
      #1;
      tempIn = {t3, t2, t1, t0};
      tempValid = 1'b1;
      @(posedge ref_clk);
      #1;
      tempValid = 1'b0;
      settle();
   endtask

   task automatic write_settle(input logic [7:0] addr, input logic [7:0] data);
      u_host.write_reg(addr, data);
      settle();
   endtask

   task automatic finish_test;
      $display("Counts: %0d compared, %0d wrong", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #500000;
      miscompares++;
      finish_test();
   end

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      miscompares = 0;
      tests_run = 0;
      rst = 1'b1;
      tempIn = '0;
      tempValid = 1'b0;
      repeat (16) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      check(pwmDuty, fan_lut_pkg::DRIVE_IDLE);
      check(tachTarget, fan_lut_pkg::TACH_IDLE);
      check({7'h00, spinActive}, 8'h00);
      read_check(fan_lut_pkg::FAN_CTRL_ADDR, fan_lut_pkg::FAN_CTRL_RESET);
      read_check(fan_lut_pkg::FAN_SPIN_ADDR, fan_lut_pkg::FAN_SPIN_RESET);
      read_check(fan_lut_pkg::LUT_CFG_ADDR, fan_lut_pkg::LUT_CFG_RESET);
      read_check(fan_lut_pkg::HYST_ADDR, fan_lut_pkg::HYST_RESET);
      u_host.write_reg(8'h20, 8'h5A);
      read_check(8'h20, 8'h00);
      for (int a = 0; a < fan_lut_pkg::LUT_DEPTH; a++) begin
         read_check(cellAddr(0, a), fan_lut_pkg::CELL_RESET);
      end
      $display("test reset values done");

      for (int s = 0; s < fan_lut_pkg::STEPS; s++) begin
         u_host.write_reg(cellAddr(s, 0), duty[s]);
         for (int c = 0; c < fan_lut_pkg::CHANNELS; c++) begin
            u_host.write_reg(cellAddr(s, c + 1), thrOf(c, s));
         end
      end
      for (int s = 0; s < fan_lut_pkg::STEPS; s++) begin
         read_check(cellAddr(s, 0), duty[s]);
         for (int c = 0; c < fan_lut_pkg::CHANNELS; c++) begin
            read_check(cellAddr(s, c + 1), thrOf(c, s));
         end
      end
      $display("test table access done");

      write_settle(fan_lut_pkg::LUT_CFG_ADDR, 8'h10);
      set_temps(8'd82, 8'd82, 8'd48, 8'd58);
      check(pwmDuty, duty[5]);
      set_temps(8'd82, 8'd97, 8'd62, 8'd58);
      check(pwmDuty, duty[6]);
      set_temps(8'd82, 8'd97, 8'd62, 8'd75);
      check(pwmDuty, duty[7]);
      read_check(fan_lut_pkg::RESULT_ADDR, duty[7]);
      u_host.write_reg(fan_lut_pkg::RESULT_ADDR, 8'h55);
      read_check(fan_lut_pkg::RESULT_ADDR, duty[7]);
      $display("test drive selection done");

      write_settle(fan_lut_pkg::HYST_ADDR, 8'h03);
      set_temps(8'd78, 8'd0, 8'd0, 8'd73);
      check(pwmDuty, duty[7]);
      set_temps(8'd0, 8'd0, 8'd0, 8'd71);
      check(pwmDuty, duty[6]);
      write_settle(fan_lut_pkg::HYST_ADDR, 8'h00);
      $display("test hysteresis done");

      for (int s = 0; s < fan_lut_pkg::STEPS; s++) begin
         u_host.write_reg(cellAddr(s, 0), tach[s]);
      end
      set_temps(8'd0, 8'd0, 8'd0, 8'd0);
      write_settle(fan_lut_pkg::LUT_CFG_ADDR, 8'hC5);
      write_settle(fan_lut_pkg::PUSHED1_ADDR, 8'd45);
      write_settle(fan_lut_pkg::PUSHED2_ADDR, 8'd40);
      check(tachTarget, tach[5]);
      write_settle(fan_lut_pkg::PUSHED1_ADDR, 8'h80);
      check(tachTarget, tach[4]);
      write_settle(fan_lut_pkg::LUT_CFG_ADDR, 8'h05);
      check(tachTarget, tach[7]);
      $display("test speed mode done");

      u_host.write_reg(fan_lut_pkg::FAN_SPIN_ADDR, 8'h0A);
      u_host.write_reg(fan_lut_pkg::FAN_CTRL_ADDR, 8'h80);
      spinCount = 0;
      for (int i = 0; i < 60; i++) begin
         if (spinActive === 1'b1) begin
            spinCount++;
            check({5'h00, spinLevel}, 8'h02);
         end
         @(posedge ref_clk);
         #1;
      end
      check(8'(spinCount), 8'(SPIN_UNIT << 2));
      $display("test spin-up done");

      write_settle(fan_lut_pkg::LUT_CFG_ADDR, 8'h35);
      check(pwmDuty, tach[0]);
      read_check(fan_lut_pkg::LUT_CFG_ADDR, 8'h35);
      u_host.write_reg(fan_lut_pkg::LUT_CFG_ADDR, 8'h00);
      read_check(fan_lut_pkg::LUT_CFG_ADDR, 8'h35);
      u_host.write_reg(cellAddr(0, 0), 8'h12);
      read_check(cellAddr(0, 0), tach[0]);
      u_host.write_reg(fan_lut_pkg::HYST_ADDR, 8'h07);
      read_check(fan_lut_pkg::HYST_ADDR, 8'h00);
      $display("test table lock done");

      rst = 1'b1;
      @(posedge ref_clk);
      #1;
      rst = 1'b0;
      check(pwmDuty, fan_lut_pkg::DRIVE_IDLE);
      check(tachTarget, fan_lut_pkg::TACH_IDLE);
      read_check(fan_lut_pkg::LUT_CFG_ADDR, fan_lut_pkg::LUT_CFG_RESET);
      read_check(cellAddr(0, 0), fan_lut_pkg::CELL_RESET);
      $display("test second reset done");
      finish_test();
   end
endmodule
